/* verilog/plmrs_pkg.sv */
package plmrs_pkg;

    // reference and field widths
    localparam int NUM_REFS   = 4;                 // reference inputs served
    localparam int RANK_W     = 3;                 // priority code width per reference
    localparam int IDX_W      = 2;                 // reference index width
    localparam int FB_PHASE_W = 16;                // shared feedback phase word width

    // mode and reference select register
    localparam logic [7:0] MODE_REG_ADDR  = 8'h38; // byte address of the register
    localparam logic [7:0] MODE_REG_RESET = 8'h03; // automatic mode, reference zero

    // field positions inside the register
    localparam int MODE_LSB = 0;                   // loop_operating_mode low bit
    localparam int MODE_MSB = 1;                   // loop_operating_mode high bit
    localparam int RSV_LSB  = 2;                   // reserved field low bit
    localparam int RSV_MSB  = 4;                   // reserved field high bit
    localparam int FBE_BIT  = 5;                   // external_feedback_enable
    localparam int SEL_LSB  = 6;                   // reference_pick_or_status low bit
    localparam int SEL_MSB  = 7;                   // reference_pick_or_status high bit

    // loop_operating_mode encodings
    localparam logic [1:0] MODE_FREE  = 2'h0;      // free-run from local oscillator
    localparam logic [1:0] MODE_HOLD  = 2'h1;      // forced holdover
    localparam logic [1:0] MODE_FORCE = 2'h2;      // forced reference lock
    localparam logic [1:0] MODE_AUTO  = 2'h3;      // automatic selection

    // priority codes
    localparam logic [2:0] RANK_TOP      = 3'h0;   // highest priority
    localparam logic [2:0] RANK_DISABLED = 3'h7;   // excluded from selection

    // loop condition
    typedef enum logic [1:0] {
        ST_FREE,
        ST_HOLD,
        ST_LOCK
    } plmrs_state_e;

    // priority code of one reference out of the packed rank vector
    function automatic logic [RANK_W-1:0] plmrs_rank_of(
        input logic [NUM_REFS*RANK_W-1:0] ranks,
        input logic [IDX_W-1:0]           idx
    );
        return ranks[idx*RANK_W +: RANK_W];
    endfunction : plmrs_rank_of

endpackage : plmrs_pkg

/* verilog/plmrs_sel_if.sv */
`timescale 1ns/1ns
// signals between the loop control and the automatic reference picker
interface plmrs_sel_if;
    logic [plmrs_pkg::NUM_REFS-1:0]                  avail;      // references currently healthy
    logic [plmrs_pkg::NUM_REFS*plmrs_pkg::RANK_W-1:0] rank;       // packed priority codes
    logic [plmrs_pkg::IDX_W-1:0]                     cur_ref;    // reference now tracked
    logic                                            cur_valid;  // loop is locked to cur_ref
    logic [plmrs_pkg::NUM_REFS-1:0]                  elig;       // available and not disabled
    logic [plmrs_pkg::RANK_W-1:0]                    best_rank;  // best code among eligible
    logic [plmrs_pkg::IDX_W-1:0]                     pick_ref;   // reference to track next
    logic                                            pick_valid; // some reference is eligible

    modport ctrl (
        output avail,
        output rank,
        output cur_ref,
        output cur_valid,
        input  elig,
        input  best_rank,
        input  pick_ref,
        input  pick_valid
    );

    modport picker (
        input  avail,
        input  rank,
        input  cur_ref,
        input  cur_valid,
        output elig,
        output best_rank,
        output pick_ref,
        output pick_valid
    );
endinterface : plmrs_sel_if

/* verilog/plmrs_ref_picker.sv */
`timescale 1ns/1ns
// purely combinational choice of the automatic-mode reference
module plmrs_ref_picker (
    plmrs_sel_if.picker sel
);

    logic [plmrs_pkg::RANK_W-1:0] best_c;    // lowest eligible code
    logic [plmrs_pkg::IDX_W-1:0]  first_c;   // lowest index holding best_c
    logic                         keep_cur;  // current reference still wins a tie

    // a reference competes only if healthy and not disabled
    // disabled code never competes
    genvar gi;
    generate
        for (gi = 0; gi < plmrs_pkg::NUM_REFS; gi++) begin : g_elig
            assign sel.elig[gi] = sel.avail[gi] &&
                (plmrs_pkg::plmrs_rank_of(sel.rank, gi[plmrs_pkg::IDX_W-1:0])
                 != plmrs_pkg::RANK_DISABLED);
        end
    endgenerate

    // best code among eligible references
    always_comb begin
        best_c = plmrs_pkg::RANK_DISABLED;
        for (int i = 0; i < plmrs_pkg::NUM_REFS; i++) begin
            if (sel.elig[i] &&
                plmrs_pkg::plmrs_rank_of(sel.rank, i[plmrs_pkg::IDX_W-1:0]) < best_c) begin
                best_c = plmrs_pkg::plmrs_rank_of(sel.rank, i[plmrs_pkg::IDX_W-1:0]);
            end
        end
    end

    // lowest index at the best code, used when the current one loses
    always_comb begin
        first_c = '0;
        for (int i = plmrs_pkg::NUM_REFS - 1; i >= 0; i--) begin
            if (sel.elig[i] &&
                plmrs_pkg::plmrs_rank_of(sel.rank, i[plmrs_pkg::IDX_W-1:0]) == best_c) begin
                first_c = i[plmrs_pkg::IDX_W-1:0];
            end
        end
    end

    // equal codes never cause a switch away from a locked reference
    assign keep_cur = sel.cur_valid && sel.elig[sel.cur_ref] &&
                      (plmrs_pkg::plmrs_rank_of(sel.rank, sel.cur_ref) == best_c);

    assign sel.pick_ref   = keep_cur ? sel.cur_ref : first_c;
    assign sel.pick_valid = |sel.elig;
    assign sel.best_rank  = best_c;

endmodule : plmrs_ref_picker

/* verilog/plmrs_top.sv */
`timescale 1ns/1ns
module plmrs_top (
    input  wire logic                                            clock,
    input  wire logic                                            rst_n,
    input  wire logic [7:0]                                      reg_addr,
    input  wire logic                                            reg_wr,
    input  wire logic [7:0]                                      reg_wdata,
    input  wire logic                                            reg_rd,
    output logic      [7:0]                                      reg_rdata_q,
    input  wire logic [plmrs_pkg::NUM_REFS-1:0]                  ref_available,
    input  wire logic [plmrs_pkg::NUM_REFS*plmrs_pkg::RANK_W-1:0] ref_rank,
    input  wire logic [plmrs_pkg::FB_PHASE_W-1:0]                fb_phase,
    output logic                                                 loop_freerun_q,
    output logic                                                 loop_holdover_q,
    output logic                                                 loop_locked_q,
    output logic      [plmrs_pkg::IDX_W-1:0]                     loop_ref_q,
    output logic      [plmrs_pkg::FB_PHASE_W-1:0]                fb_correction_q
);

    // register fields, kept as written
    logic [1:0]                  mode_q;     // loop_operating_mode
    logic [2:0]                  rsv_q;      // reserved bits, stored only
    logic                        fbe_q;      // external_feedback_enable
    logic [plmrs_pkg::IDX_W-1:0] sel_q;      // forced reference pick

    // loop condition and tracked reference
    plmrs_pkg::plmrs_state_e     state_q;    // current loop condition
    plmrs_pkg::plmrs_state_e     state_d;    // next loop condition
    logic [plmrs_pkg::IDX_W-1:0] act_ref_q;  // last selected reference
    logic [plmrs_pkg::IDX_W-1:0] act_ref_d;  // next selected reference

    // decoded bus strobes and mode flags
    wire hit      = (reg_addr == plmrs_pkg::MODE_REG_ADDR); // register decoded
    wire wr_hit   = reg_wr && hit;                          // write to the register
    wire rd_hit   = reg_rd && hit;                          // read of the register
    wire mode_auto  = (mode_q == plmrs_pkg::MODE_AUTO);     // automatic mode active
    wire mode_force = (mode_q == plmrs_pkg::MODE_FORCE);    // forced lock active
    wire forced_ok  = ref_available[sel_q];                 // forced reference healthy

    // read value: status field replaces control field in automatic mode
    wire [plmrs_pkg::IDX_W-1:0] sel_view = mode_auto ? act_ref_q : sel_q;
    wire [7:0]                  rd_word  = {sel_view, fbe_q, rsv_q, mode_q};

    // feedback correction value
    wire [plmrs_pkg::FB_PHASE_W-1:0] corr_d = fbe_q ? fb_phase : '0;

    // automatic picker wiring
    plmrs_sel_if sel_if ();

    assign sel_if.avail     = ref_available;
    assign sel_if.rank      = ref_rank;
    assign sel_if.cur_ref   = act_ref_q;
    assign sel_if.cur_valid = (state_q == plmrs_pkg::ST_LOCK);

    plmrs_ref_picker u_picker (
        .sel (sel_if.picker)
    );

    // register write path; all fields stored so readback matches writes outside automatic mode
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= plmrs_pkg::MODE_REG_RESET[plmrs_pkg::MODE_MSB:plmrs_pkg::MODE_LSB];
            rsv_q  <= plmrs_pkg::MODE_REG_RESET[plmrs_pkg::RSV_MSB:plmrs_pkg::RSV_LSB];
            fbe_q  <= plmrs_pkg::MODE_REG_RESET[plmrs_pkg::FBE_BIT];
            sel_q  <= plmrs_pkg::MODE_REG_RESET[plmrs_pkg::SEL_MSB:plmrs_pkg::SEL_LSB];
        end else if (wr_hit) begin
            mode_q <= reg_wdata[plmrs_pkg::MODE_MSB:plmrs_pkg::MODE_LSB];
            rsv_q  <= reg_wdata[plmrs_pkg::RSV_MSB:plmrs_pkg::RSV_LSB];
            fbe_q  <= reg_wdata[plmrs_pkg::FBE_BIT];
            sel_q  <= reg_wdata[plmrs_pkg::SEL_MSB:plmrs_pkg::SEL_LSB];
        end
    end

    // read data, one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_q <= rd_hit ? rd_word : 8'h00;
        end
    end

    // next loop condition from the mode field
    always_comb begin
        state_d   = state_q;
        act_ref_d = act_ref_q;
        case (mode_q)
            plmrs_pkg::MODE_FREE: begin
                state_d = plmrs_pkg::ST_FREE;
            end
            plmrs_pkg::MODE_HOLD: begin
                state_d = plmrs_pkg::ST_HOLD;
            end
            plmrs_pkg::MODE_FORCE: begin
                if (forced_ok) begin
                    state_d   = plmrs_pkg::ST_LOCK;
                    act_ref_d = sel_q;
                end else begin
                    state_d = plmrs_pkg::ST_HOLD;
                end
            end
            default: begin
                if (sel_if.pick_valid) begin
                    state_d   = plmrs_pkg::ST_LOCK;
                    act_ref_d = sel_if.pick_ref;
                end else begin
                    state_d = plmrs_pkg::ST_HOLD;
                end
            end
        endcase
    end

    // loop condition and the flops that drive the status outputs
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q         <= plmrs_pkg::ST_FREE;
            act_ref_q       <= '0;
            loop_freerun_q  <= 1'b1;
            loop_holdover_q <= 1'b0;
            loop_locked_q   <= 1'b0;
            loop_ref_q      <= '0;
        end else begin
            state_q         <= state_d;
            act_ref_q       <= act_ref_d;
            loop_freerun_q  <= (state_d == plmrs_pkg::ST_FREE);
            loop_holdover_q <= (state_d == plmrs_pkg::ST_HOLD);
            loop_locked_q   <= (state_d == plmrs_pkg::ST_LOCK);
            loop_ref_q      <= act_ref_d;
        end
    end

    // feedback phase correction, shared word regardless of its source loop
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fb_correction_q <= '0;
        end else begin
            fb_correction_q <= corr_d;
        end
    end

    // checks on the loop control
    property p_free;
        @(posedge clock) disable iff (!rst_n)
        mode_q == plmrs_pkg::MODE_FREE |=> loop_freerun_q && !loop_locked_q && !loop_holdover_q;
    endproperty
    a_free: assert property (p_free) else $error("free-run mode not followed");

    property p_hold;
        @(posedge clock) disable iff (!rst_n)
        mode_q == plmrs_pkg::MODE_HOLD |=> loop_holdover_q && loop_ref_q == $past(act_ref_q);
    endproperty
    a_hold: assert property (p_hold) else $error("forced holdover lost last reference");

    property p_force_ok;
        @(posedge clock) disable iff (!rst_n)
        mode_force && forced_ok |=> loop_locked_q && loop_ref_q == $past(sel_q);
    endproperty
    a_force_ok: assert property (p_force_ok) else $error("forced lock on wrong reference");

    property p_force_fail;
        @(posedge clock) disable iff (!rst_n)
        mode_force && !forced_ok |=> loop_holdover_q && $stable(act_ref_q);
    endproperty
    a_force_fail: assert property (p_force_fail) else $error("forced mode switched away");

    property p_auto_none;
        @(posedge clock) disable iff (!rst_n)
        mode_auto && sel_if.elig == '0 |=> loop_holdover_q && !loop_locked_q;
    endproperty
    a_auto_none: assert property (p_auto_none) else $error("no holdover without references");

    property p_auto_best;
        @(posedge clock) disable iff (!rst_n)
        mode_auto && sel_if.pick_valid |=> loop_locked_q
            && $past(ref_available[sel_if.pick_ref])
            && plmrs_pkg::plmrs_rank_of($past(ref_rank), loop_ref_q) == $past(sel_if.best_rank);
    endproperty
    a_auto_best: assert property (p_auto_best) else $error("automatic pick not best rank");

    property p_rank_off;
        @(posedge clock) disable iff (!rst_n)
        $past(mode_auto) && loop_locked_q |->
            plmrs_pkg::plmrs_rank_of($past(ref_rank), loop_ref_q) != plmrs_pkg::RANK_DISABLED;
    endproperty
    a_rank_off: assert property (p_rank_off) else $error("disabled reference selected");

    property p_no_revert;
        @(posedge clock) disable iff (!rst_n)
        mode_auto && sel_if.cur_valid && sel_if.elig[act_ref_q] &&
            plmrs_pkg::plmrs_rank_of(ref_rank, act_ref_q) == sel_if.best_rank
            |=> $stable(act_ref_q);
    endproperty
    a_no_revert: assert property (p_no_revert) else $error("switched among equal ranks");

    property p_fb_on;
        @(posedge clock) disable iff (!rst_n)
        fbe_q |=> fb_correction_q == $past(fb_phase);
    endproperty
    a_fb_on: assert property (p_fb_on) else $error("feedback phase not applied");

    property p_fb_off;
        @(posedge clock) disable iff (!rst_n)
        !fbe_q |=> fb_correction_q == '0;
    endproperty
    a_fb_off: assert property (p_fb_off) else $error("feedback applied while disabled");

    property p_status_rd;
        @(posedge clock) disable iff (!rst_n)
        rd_hit && mode_auto |=> reg_rdata_q[plmrs_pkg::SEL_MSB:plmrs_pkg::SEL_LSB]
            == $past(act_ref_q);
    endproperty
    a_status_rd: assert property (p_status_rd) else $error("status field wrong in automatic");

    property p_auto_wr;
        @(posedge clock) disable iff (!rst_n)
        mode_auto && wr_hit && sel_if.pick_valid |=> loop_ref_q == $past(sel_if.pick_ref);
    endproperty
    a_auto_wr: assert property (p_auto_wr) else $error("select write moved selection");

endmodule : plmrs_top

/* verif/plmrs_ref_model.sv */
`timescale 1ns/1ns
// behavioural far side: reference health flags and the shared feedback phase
module plmrs_ref_model (
    input  wire logic                                clock,         // system clock
    input  wire logic                                rst_n,         // async reset, active low
    input  wire logic [plmrs_pkg::NUM_REFS-1:0]      avail_cmd,     // health the bench commands
    output logic      [plmrs_pkg::NUM_REFS-1:0]      ref_available, // per-reference healthy flags
    output logic      [plmrs_pkg::FB_PHASE_W-1:0]    fb_phase       // shared phase measurement
);
    // health follows the command; a real monitor would add qualification delay
    assign ref_available = avail_cmd;

    // phase word moves every cycle, so a stale or late copy never matches
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fb_phase <= 16'h5a3c;
        end else begin
            fb_phase <= fb_phase + 16'h1357;
        end
    end
endmodule : plmrs_ref_model

/* verif/plmrs_top_tb.sv */
`timescale 1ns/1ns
// self-checking bench for the loop mode and reference select block
module plmrs_top_tb;
    logic        clock;           // 20 MHz system clock
    logic        rst_n;           // async reset, active low
    logic [7:0]  reg_addr;        // register address
    logic        reg_wr;          // write strobe
    logic [7:0]  reg_wdata;       // write data
    logic        reg_rd;          // read strobe
    logic [7:0]  reg_rdata_q;     // read data
    logic [3:0]  avail_cmd;       // health pattern for the model
    logic [3:0]  ref_available;   // health seen by the design
    logic [11:0] ref_rank;        // packed priority codes
    logic [15:0] fb_phase;        // shared phase word
    logic        loop_freerun_q;  // free-run status
    logic        loop_holdover_q; // holdover status
    logic        loop_locked_q;   // lock status
    logic [1:0]  loop_ref_q;      // selected reference
    logic [15:0] fb_correction_q; // applied correction
    logic [7:0]  rd_val;          // last read value
    logic [15:0] cap;             // captured phase word
    int          fails;           // mismatch count
    int          samples_checked; // comparison count
    int          cycles;          // timeout counter
    wire  [2:0]  status = {loop_freerun_q, loop_holdover_q, loop_locked_q};

    // one table row: register write, reference inputs, expected results
    typedef struct packed {
        logic [7:0]  wdata; // register value written
        logic [3:0]  avail; // reference health
        logic [11:0] rank;  // priority codes
        logic [2:0]  st;    // freerun, holdover, locked
        logic        cref;  // compare loop_ref_q
        logic [1:0]  sref;  // expected reference
        logic [7:0]  rd;    // expected readback
    } plmrs_row_s;

    // reserved bits 4:2 are always written as zero
    // reserved kept zero
    plmrs_row_s rows [17] = '{
        '{8'h03, 4'h1, 12'h000, 3'h1, 1'b1, 2'h0, 8'h03},
        '{8'h03, 4'h3, 12'h000, 3'h1, 1'b1, 2'h0, 8'h03},
        '{8'h03, 4'h2, 12'h000, 3'h1, 1'b1, 2'h1, 8'h43},
        '{8'h03, 4'h3, 12'h000, 3'h1, 1'b1, 2'h1, 8'h43},
        '{8'h03, 4'h3, 12'h008, 3'h1, 1'b1, 2'h0, 8'h03},
        '{8'h03, 4'h1, 12'h007, 3'h2, 1'b1, 2'h0, 8'h03},
        '{8'h03, 4'hf, 12'h007, 3'h1, 1'b1, 2'h1, 8'h43},
        '{8'hc3, 4'hf, 12'h007, 3'h1, 1'b1, 2'h1, 8'h43},
        '{8'h82, 4'hf, 12'h000, 3'h1, 1'b1, 2'h2, 8'h82},
        '{8'h82, 4'hb, 12'h000, 3'h2, 1'b1, 2'h2, 8'h82},
        '{8'hc2, 4'h7, 12'h000, 3'h2, 1'b1, 2'h2, 8'hc2},
        '{8'h42, 4'h2, 12'h000, 3'h1, 1'b1, 2'h1, 8'h42},
        '{8'h01, 4'hf, 12'h000, 3'h2, 1'b1, 2'h1, 8'h01},
        '{8'hc1, 4'hf, 12'h000, 3'h2, 1'b1, 2'h1, 8'hc1},
        '{8'h00, 4'hf, 12'h000, 3'h4, 1'b0, 2'h0, 8'h00},
        '{8'hc0, 4'h0, 12'h000, 3'h4, 1'b0, 2'h0, 8'hc0},
        '{8'h23, 4'h1, 12'h000, 3'h1, 1'b1, 2'h0, 8'h23}
    };

    plmrs_top i_dut (
        .clock           (clock),
        .rst_n           (rst_n),
        .reg_addr        (reg_addr),
        .reg_wr          (reg_wr),
        .reg_wdata       (reg_wdata),
        .reg_rd          (reg_rd),
        .reg_rdata_q     (reg_rdata_q),
        .ref_available   (ref_available),
        .ref_rank        (ref_rank),
        .fb_phase        (fb_phase),
        .loop_freerun_q  (loop_freerun_q),
        .loop_holdover_q (loop_holdover_q),
        .loop_locked_q   (loop_locked_q),
        .loop_ref_q      (loop_ref_q),
        .fb_correction_q (fb_correction_q)
    );

    plmrs_ref_model i_refs (
        .clock         (clock),
        .rst_n         (rst_n),
        .avail_cmd     (avail_cmd),
        .ref_available (ref_available),
        .fb_phase      (fb_phase)
    );

    // free-running clock
    initial clock = 1'b0;
    always #25 clock = ~clock;

    // prints counts and verdict, then stops
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    // hang guard, far above the roughly 90 cycles the run needs
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            $display("[ERR] t=%0t timeout seen=%h exp=%h", $time, cycles, 0);
            end_of_test();
        end
    end

    // compares one value against its expectation
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // single-cycle write strobe, entered and left at a falling edge
    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        reg_addr  = addr;
        reg_wdata = data;
        reg_wr    = 1'b1;
        @(negedge clock);
        reg_wr    = 1'b0;
    endtask : reg_write

    // single-cycle read strobe; data is registered on the strobed edge
    task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
        reg_addr = addr;
        reg_rd   = 1'b1;
        @(negedge clock);
        reg_rd   = 1'b0;
        data     = reg_rdata_q;
    endtask : reg_read

    // main sequence
    initial begin
        {rst_n, reg_addr, reg_wr, reg_wdata, reg_rd, avail_cmd, ref_rank} = '0;
        fails = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (2) @(negedge clock);
        check({11'h0, status, loop_ref_q}, 16'h0010);
        check(fb_correction_q, 16'h0000);
        check({8'h0, reg_rdata_q}, 16'h0000);
        rst_n = 1'b1;
        @(negedge clock);
        check({13'h0, status}, 16'h0002);
        reg_read(plmrs_pkg::MODE_REG_ADDR, rd_val);
        check({8'h0, rd_val}, 16'h0003);
        $display("test reset done");
        // table of mode, priority and selection cases
        foreach (rows[i]) begin
            avail_cmd = rows[i].avail;
            ref_rank  = rows[i].rank;
            reg_write(plmrs_pkg::MODE_REG_ADDR, rows[i].wdata);
            repeat (2) @(negedge clock);
            check({13'h0, status}, {13'h0, rows[i].st});
            if (rows[i].cref) begin
                check({14'h0, loop_ref_q}, {14'h0, rows[i].sref});
            end
            reg_read(plmrs_pkg::MODE_REG_ADDR, rd_val);
            check({8'h0, rd_val}, {8'h0, rows[i].rd});
        end
        $display("test table done");
        // feedback enabled: correction is last cycle's shared phase
        repeat (2) begin
            cap = fb_phase;
            @(negedge clock);
            check(fb_correction_q, cap);
        end
        reg_write(plmrs_pkg::MODE_REG_ADDR, 8'h03);
        repeat (2) @(negedge clock);
        check(fb_correction_q, 16'h0000);
        $display("test feedback done");
        // write and read in one cycle: read returns the old value
        reg_addr  = plmrs_pkg::MODE_REG_ADDR;
        reg_wdata = 8'h01;
        {reg_wr, reg_rd} = 2'b11;
        @(negedge clock);
        {reg_wr, reg_rd} = 2'b00;
        check({8'h0, reg_rdata_q}, 16'h0003);
        @(negedge clock);
        reg_read(plmrs_pkg::MODE_REG_ADDR, rd_val);
        check({8'h0, rd_val}, 16'h0001);
        // unmapped address: write ignored, read returns zero
        reg_write(8'h39, 8'h00);
        reg_read(plmrs_pkg::MODE_REG_ADDR, rd_val);
        check({8'h0, rd_val}, 16'h0001);
        @(negedge clock);
        reg_read(8'h39, rd_val);
        check({8'h0, rd_val}, 16'h0000);
        $display("test bus done");
        // second reset in mid-run restores automatic mode
        rst_n = 1'b0;
        avail_cmd = 4'h4;
        @(negedge clock);
        check({11'h0, status, loop_ref_q}, 16'h0010);
        rst_n = 1'b1;
        repeat (2) @(negedge clock);
        check({11'h0, status, loop_ref_q}, 16'h0006);
        reg_read(plmrs_pkg::MODE_REG_ADDR, rd_val);
        check({8'h0, rd_val}, 16'h0083);
        $display("test mid reset done");
        end_of_test();
    end
endmodule : plmrs_top_tb
